// ==== pkg/sgc_pkg.sv ====
// Shared types and constants of the graphics DRAM command interface
package sgc_pkg;

  // ----------------------------------------------------------------
  // Register map, byte addresses on haddr[7:0]
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h04;
  localparam logic [7:0] REG_COLOUR = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_ROWS = 8'h14;
  localparam logic [7:0] REG_REFRESH = 8'h18;
  localparam logic CTRL_RESET = 1'b1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ----------------------------------------------------------------
  // Address pin fields
  // ----------------------------------------------------------------
  localparam int BL_LSB = 0;
  localparam int BT_BIT = 3;
  localparam int CL_LSB = 4;
  localparam int WSINGLE_BIT = 9;
  localparam int LOAD_COLOUR_BIT = 6;
  localparam int LOAD_MASK_BIT = 5;
  localparam int BANK_BIT = 10;
  localparam int AUTO_PRE_BIT = 9;
  localparam int PRE_ALL_BIT = 9;
  localparam logic [2:0] CL_CODE2 = 3'h2;
  localparam logic [2:0] BL_CODE2 = 3'h1;
  localparam logic [2:0] BL_CODE4 = 3'h2;
  localparam logic [2:0] BL_CODE8 = 3'h3;
  localparam logic [2:0] BL_CODE_FULL = 3'h7;
  localparam logic [8:0] FULL_PAGE_LEN = 9'h100;
  localparam int MEM_WORDS = 524288;

  typedef enum logic [3:0] {
    CMD_NOP, CMD_MODE, CMD_SMODE, CMD_REFRESH, CMD_ACT,
    CMD_READ, CMD_WRITE, CMD_BWRITE, CMD_STOP, CMD_PRE
  } sgc_cmd_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic graphics_select;
    logic [10:0] addr;
    logic [3:0] dqm;
  } sgc_pins_t;

  typedef struct packed {
    logic [10:0] mode;
    logic [31:0] colour;
    logic [31:0] mask;
    logic [1:0] open;
    logic [1:0] wpb;
    logic burst;
    logic power_down;
    logic self_ref;
    logic [9:0] row_a;
    logic [9:0] row_b;
    logic [9:0] ref_row;
  } sgc_status_t;

  function automatic logic [31:0] byte_expand(logic [3:0] b);
    return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  endfunction : byte_expand

endpackage : sgc_pkg

// ==== verilog/sgc_burst_addr.sv ====
// Column address of one burst beat, sequential or interleaved
`timescale 1ns/1ps
module sgc_burst_addr (
  input wire logic [7:0] start,
  input wire logic [7:0] beat,
  input wire logic [8:0] len,
  input wire logic interleave,
  output logic [7:0] col
);
  logic [7:0] wrap;
  logic [7:0] step;

  assign wrap = 8'(len - 9'h1);
  // Only the low bits inside the burst length move
  assign step = interleave ? (start ^ beat) : 8'(start + beat);
  assign col = (start & ~wrap) | (step & wrap);
endmodule : sgc_burst_addr

// ==== verilog/sgc_ahb_regs.sv ====
// AHB-Lite register slave of the command interface
`timescale 1ns/1ps
module sgc_ahb_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input sgc_pkg::sgc_status_t status,
  output logic ctrl_en,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  import sgc_pkg::*;

  typedef struct packed {
    logic pend;
    logic [7:0] waddr;
    logic en;
    logic [31:0] rdata;
    logic ready;
  } sgc_regs_t;

  localparam sgc_regs_t REGS_RESET = '{pend: 1'b0, waddr: 8'h00,
    en: CTRL_RESET, rdata: 32'h0, ready: 1'b1};

  sgc_regs_t st_q, st_d;
  logic take;

  assign take = hsel && hready && htrans[1];

  always_comb begin
    st_d = st_q;
    st_d.ready = 1'b1;
    st_d.pend = 1'b0;
    if (st_q.pend && st_q.waddr == REG_CTRL) begin
      st_d.en = hwdata[0];
    end
    if (take) begin
      st_d.pend = hwrite && hsize == HSIZE_WORD;
      st_d.waddr = haddr[7:0];
      case (haddr[7:0])
        REG_CTRL: st_d.rdata = {31'h0, st_q.en};
        REG_MODE: st_d.rdata = {21'h0, status.mode};
        REG_COLOUR: st_d.rdata = status.colour;
        REG_MASK: st_d.rdata = status.mask;
        REG_STATUS: st_d.rdata = {25'h0, status.self_ref,
          status.power_down, status.burst, status.wpb, status.open};
        REG_ROWS: st_d.rdata = {6'h0, status.row_b, 6'h0, status.row_a};
        REG_REFRESH: st_d.rdata = {22'h0, status.ref_row};
        default: st_d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= REGS_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign ctrl_en = st_q.en;
  assign hrdata = st_q.rdata;
  assign hreadyout = st_q.ready;
  assign hresp = 1'b0;
endmodule : sgc_ahb_regs

// ==== verilog/sgc_top.sv ====
// Command decoder, mode registers and data path of the graphics DRAM
`timescale 1ns/1ps
module sgc_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cke,
  input sgc_pkg::sgc_pins_t pins,
  input wire logic [31:0] dq_in,
  output logic [31:0] dq_out,
  output logic [31:0] dq_oe,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  import sgc_pkg::*;

  typedef struct packed {
    logic cke_prev;
    logic [10:0] mode;
    logic [31:0] colour;
    logic [31:0] mask;
    logic [1:0] open;
    logic [1:0] wpb;
    logic [1:0][9:0] row;
    logic [9:0] ref_row;
    logic pd;
    logic sref;
    logic act;
    logic wr;
    logic ap;
    logic bank;
    logic [7:0] start;
    logic [8:0] beat;
    logic [8:0] len;
    logic v0;
    logic v1;
    logic [31:0] d0;
    logic [31:0] d1;
    logic [3:0] dqm1;
    logic [31:0] dout;
    logic [31:0] doe;
  } sgc_core_t;

  sgc_core_t st_q, st_d;
  sgc_cmd_t cmd;
  sgc_status_t status;
  logic ctrl_en, col_cmd, stop_ok, pre_hit, go, cl3;
  logic cur_bank, cur_wr, wr_en, blk_en;
  logic [7:0] cur_start, cur_beat, col;
  logic [8:0] cur_len;
  logic [18:0] idx;
  logic [31:0] mem_rd, wpb_m, wr_bits;
  logic [7:0][31:0] blk_bits;
  logic [31:0] mem [0:MEM_WORDS-1];

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  function automatic sgc_cmd_t decode(sgc_pins_t p);
    sgc_cmd_t c;
    case ({p.ras_n, p.cas_n, p.we_n})
      3'b000: c = p.graphics_select ? CMD_SMODE : CMD_MODE;
      3'b001: c = CMD_REFRESH;
      3'b011: c = CMD_ACT;
      3'b101: c = CMD_READ;
      3'b100: c = p.graphics_select ? CMD_BWRITE : CMD_WRITE;
      3'b110: c = CMD_STOP;
      3'b010: c = CMD_PRE;
      default: c = CMD_NOP;
    endcase
    return c;
  endfunction : decode

  // Reserved codes fall back to a single beat
  function automatic logic [8:0] burst_len(logic [10:0] m, logic w);
    logic [8:0] l;
    l = 9'h1;
    if (!(w && m[WSINGLE_BIT])) begin
      case (m[BL_LSB+:3])
        BL_CODE2: l = m[BT_BIT] ? 9'h1 : 9'h2;
        BL_CODE4: l = 9'h4;
        BL_CODE8: l = 9'h8;
        BL_CODE_FULL: l = m[BT_BIT] ? 9'h1 : FULL_PAGE_LEN;
        default: l = 9'h1;
      endcase
    end
    return l;
  endfunction : burst_len

  // Commands count only after an edge with clock enable high
  assign cmd = (st_q.cke_prev && ctrl_en && !pins.cs_n) ?
    decode(pins) : CMD_NOP;
  assign cl3 = st_q.mode[CL_LSB+:3] != CL_CODE2;
  assign col_cmd = cmd == CMD_READ || cmd == CMD_WRITE ||
    cmd == CMD_BWRITE;
  assign stop_ok = cmd == CMD_STOP && st_q.len == FULL_PAGE_LEN;
  assign pre_hit = cmd == CMD_PRE && (pins.addr[PRE_ALL_BIT] ||
    pins.addr[BANK_BIT] == st_q.bank);
  assign go = st_q.cke_prev && st_q.act && !col_cmd && !stop_ok &&
    !pre_hit;

  // ----------------------------------------------------------------
  // Burst addressing
  // ----------------------------------------------------------------
  assign cur_bank = col_cmd ? pins.addr[BANK_BIT] : st_q.bank;
  assign cur_start = col_cmd ? pins.addr[7:0] : st_q.start;
  assign cur_beat = col_cmd ? 8'h00 : st_q.beat[7:0];
  assign cur_wr = col_cmd ? (cmd != CMD_READ) : st_q.wr;
  assign cur_len = col_cmd ? burst_len(st_q.mode, cur_wr) : st_q.len;

  sgc_burst_addr u_addr (
    .start(cur_start),
    .beat(cur_beat),
    .len(cur_len),
    .interleave(st_q.mode[BT_BIT]),
    .col(col)
  );

  // ----------------------------------------------------------------
  // Array and write masks
  // ----------------------------------------------------------------
  assign idx = {cur_bank, st_q.row[cur_bank], col};
  assign mem_rd = mem[idx];
  assign wpb_m = st_q.wpb[cur_bank] ? st_q.mask : 32'hffffffff;
  assign wr_bits = wpb_m & ~byte_expand(pins.dqm);
  assign wr_en = (go && st_q.wr) || cmd == CMD_WRITE;
  assign blk_en = cmd == CMD_BWRITE;

  for (genvar j = 0; j < 8; j++) begin : g_col
    // Bit j of each byte lane enables column j of the block
    assign blk_bits[j] = wr_bits & byte_expand({dq_in[24+j],
      dq_in[16+j], dq_in[8+j], dq_in[j]});
  end

  always_ff @(posedge hclk) begin
    if (wr_en) begin
      mem[idx] <= (mem[idx] & ~wr_bits) | (dq_in & wr_bits);
    end
    for (int k = 0; k < 8; k++) begin
      if (blk_en) begin
        mem[{idx[18:3], 3'(k)}] <= (mem[{idx[18:3], 3'(k)}] &
          ~blk_bits[k]) | (st_q.colour & blk_bits[k]);
      end
    end
  end

  // ----------------------------------------------------------------
  // State update
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.cke_prev = cke;
    if (st_q.cke_prev) begin
      st_d.pd = 1'b0;
      st_d.sref = 1'b0;
      st_d.dqm1 = pins.dqm;
      // Read pipe: fetch, one more stage for latency three
      st_d.v1 = st_q.v0;
      st_d.d1 = st_q.d0;
      st_d.v0 = (go && !st_q.wr) || cmd == CMD_READ;
      st_d.d0 = mem_rd;
      st_d.dout = cl3 ? st_q.d1 : st_q.d0;
      st_d.doe = (cl3 ? st_q.v1 : st_q.v0) ?
        ~byte_expand(st_q.dqm1) : 32'h0;
      if (go) begin
        st_d.beat = st_q.beat + 9'h1;
        if (st_q.len != FULL_PAGE_LEN &&
            st_q.beat + 9'h1 == st_q.len) begin
          st_d.act = 1'b0;
          if (st_q.ap) begin
            st_d.open[st_q.bank] = 1'b0;
          end
        end
      end
      if (stop_ok || pre_hit) begin
        st_d.act = 1'b0;
      end
      if (!cke && cmd == CMD_NOP) begin
        st_d.pd = 1'b1;
      end
      case (cmd)
        CMD_MODE: st_d.mode = pins.addr;
        CMD_SMODE: begin
          // Both bits set loads both registers
          if (pins.addr[LOAD_COLOUR_BIT]) begin
            st_d.colour = dq_in;
          end
          if (pins.addr[LOAD_MASK_BIT]) begin
            st_d.mask = dq_in;
          end
        end
        CMD_REFRESH: begin
          if (!cke) begin
            st_d.sref = 1'b1;
          end else if (st_q.open == 2'b00) begin
            st_d.ref_row = st_q.ref_row + 10'h1;
          end
        end
        CMD_ACT: begin
          st_d.open[pins.addr[BANK_BIT]] = 1'b1;
          st_d.row[pins.addr[BANK_BIT]] = pins.addr[9:0];
          st_d.wpb[pins.addr[BANK_BIT]] = pins.graphics_select;
        end
        CMD_READ, CMD_WRITE: begin
          st_d.act = cur_len != 9'h1;
          st_d.wr = cur_wr;
          st_d.bank = cur_bank;
          st_d.start = cur_start;
          st_d.beat = 9'h1;
          st_d.len = cur_len;
          st_d.ap = pins.addr[AUTO_PRE_BIT];
          if (cur_len == 9'h1 && pins.addr[AUTO_PRE_BIT]) begin
            st_d.open[cur_bank] = 1'b0;
          end
        end
        CMD_BWRITE: begin
          st_d.act = 1'b0;
          if (pins.addr[AUTO_PRE_BIT]) begin
            st_d.open[cur_bank] = 1'b0;
          end
        end
        CMD_PRE: begin
          if (pins.addr[PRE_ALL_BIT]) begin
            st_d.open = 2'b00;
          end else begin
            st_d.open[pins.addr[BANK_BIT]] = 1'b0;
          end
        end
        default: st_d.act = st_d.act;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dq_out = st_q.dout;
  assign dq_oe = st_q.doe;

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  assign status = '{mode: st_q.mode, colour: st_q.colour,
    mask: st_q.mask, open: st_q.open, wpb: st_q.wpb, burst: st_q.act,
    power_down: st_q.pd, self_ref: st_q.sref, row_a: st_q.row[0],
    row_b: st_q.row[1], ref_row: st_q.ref_row};

  sgc_ahb_regs u_regs (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .status(status),
    .ctrl_en(ctrl_en),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_mode_load: assert property (
    cmd == CMD_MODE |=> st_q.mode == $past(pins.addr))
    else $error("mode register not loaded in one clock");

  a_colour_only: assert property (
    cmd == CMD_SMODE && pins.addr[LOAD_COLOUR_BIT] &&
    !pins.addr[LOAD_MASK_BIT] |=>
    st_q.colour == $past(dq_in) && $stable(st_q.mask))
    else $error("colour load wrong or mask disturbed");

  a_pre_all: assert property (
    cmd == CMD_PRE && pins.addr[PRE_ALL_BIT] |=> st_q.open == 2'b00)
    else $error("precharge all left a bank open");

  a_wpb_fix: assert property (
    cmd == CMD_ACT |=>
    st_q.wpb[$past(pins.addr[BANK_BIT])] == $past(pins.graphics_select))
    else $error("write per bit not taken at activate");

  a_read_lat: assert property (
    cmd == CMD_READ && cl3 && pins.dqm == 4'h0 && cke ##1
    (pins.dqm == 4'h0 && cke) [*2] |=> dq_oe == 32'hffffffff)
    else $error("read data not driven at latency three");

  a_dqm_read: assert property (
    pins.dqm[0] && st_q.cke_prev && cke ##1 cke |=> dq_oe[7:0] == 8'h00)
    else $error("read byte mask latency is not two");

  a_stop_halts: assert property (
    cmd == CMD_STOP && st_q.act && st_q.len == FULL_PAGE_LEN |=> !st_q.act)
    else $error("full page burst not stopped");

  a_pd_entry: assert property (
    cmd == CMD_NOP && st_q.cke_prev && !cke |=> st_q.pd && !st_q.cke_prev)
    else $error("power down not entered");

  a_refresh_row: assert property (
    cmd == CMD_REFRESH && cke && st_q.open == 2'b00 |=>
    st_q.ref_row == $past(st_q.ref_row) + 10'h1)
    else $error("refresh row counter did not advance");
endmodule : sgc_top

// ==== verification/sgc_ctrl_model.sv ====
// Memory controller model that drives the command pins of the device
`timescale 1ns/1ps
module sgc_ctrl_model (
  input wire logic hclk,
  input wire logic [31:0] dq_out,
  input wire logic [31:0] dq_oe,
  output logic cke,
  output sgc_pkg::sgc_pins_t pins,
  output logic [31:0] dq_in
);
  import sgc_pkg::*;
  logic [31:0] oe_q[$];
  logic [31:0] rd_q[$];

  // --------
  // Power-up state
  // --------
  initial begin
    cke = 1'b1;
    pins = {5'h1e, 11'h000, 4'hf};
    dq_in = 32'h0;
  end

  // Every word the device drives is logged for the bench
  always @(negedge hclk) begin
    if (dq_oe != 32'h0) begin
      oe_q.push_back(dq_oe);
      rd_q.push_back(dq_out);
    end
  end

  // --------
  // Command tasks; callers keep the spacing between commands
  // --------
  task automatic cmd(input logic [2:0] rcw, input logic gs,
                     input logic [10:0] a, input logic [31:0] d,
                     input logic [3:0] m);
    pins <= {1'b0, rcw, gs, a, m};
    dq_in <= d;
    @(posedge hclk);
  endtask : cmd

  // Released data lines toggle so a stale word is never seen
  task automatic nop(input logic [3:0] m);
    cmd(3'b111, 1'b0, 11'h000, ~dq_in, m);
  endtask : nop

  task automatic idle(input int n);
    repeat (n) nop(4'h0);
  endtask : idle

  task automatic set_cke(input logic v);
    cke <= v;
    nop(4'h0);
  endtask : set_cke

  // Strobes with chip select high; the decoder must not see them
  task automatic desel(input logic [10:0] a);
    pins <= {1'b1, 3'b000, 1'b0, a, 4'h0};
    @(posedge hclk);
  endtask : desel

  task automatic clear;
    oe_q.delete();
    rd_q.delete();
  endtask : clear
endmodule : sgc_ctrl_model

// ==== verification/graphics_sync_dram_command_interface_bench.sv ====
// Self-checking bench of the graphics DRAM command interface
`timescale 1ns/1ps
module graphics_sync_dram_command_interface_bench;
  import sgc_pkg::*;
  localparam logic [31:0] COL = 32'hc3a5_5a3c;
  localparam logic [31:0] MSK = 32'h0ff0_f00f;
  localparam logic [31:0] D1 = 32'h1234_5678;
  localparam int LIMIT = 8000;
  // Power-up wait in clocks: 200 us at 40 ns
  localparam int POWER_UP = 5000;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, cke;
  logic [31:0] haddr, hwdata, hrdata, dq_out, dq_oe, dq_in, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  sgc_pins_t pins;
  int fail_count, n_tests, cycles;

  sgc_top dut (.hclk(hclk), .hresetn(hresetn), .cke(cke), .pins(pins),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));
  sgc_ctrl_model ctl (.hclk(hclk), .dq_out(dq_out), .dq_oe(dq_oe),
    .cke(cke), .pins(pins), .dq_in(dq_in));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      complete_run();
    end
  end

  // --------
  // Tasks
  // --------
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, input logic sel = 1'b1,
                     input logic [23:0] hi = 24'h0);
    hsel <= sel;
    htrans <= 2'b10;
    haddr <= {hi, a};
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb

  task automatic rbits(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    check(rd & m, exp);
  endtask : rbits

  task automatic beat(input logic [31:0] ed, input logic [31:0] eo);
    check(ctl.oe_q.pop_front(), eo);
    check(ctl.rd_q.pop_front() & eo, ed & eo);
  endtask : beat

  task automatic rdw(input logic [10:0] a);
    ctl.clear();
    ctl.cmd(3'b101, 1'b0, a, 32'h0, 4'h0);
    ctl.idle(6);
  endtask : rdw

  // Read at column a, then a stop or precharge three clocks later
  task automatic cut(input logic [2:0] rcw, input logic [10:0] a,
                     input logic [31:0] n);
    ctl.clear();
    ctl.cmd(3'b101, 1'b0, a, 32'h0, 4'h0);
    ctl.idle(2);
    ctl.cmd(rcw, 1'b0, 11'h000, 32'h0, 4'h0);
    ctl.idle(8);
    check(32'(ctl.oe_q.size()), n);
  endtask : cut

  // --------
  // Main sequence
  // --------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (POWER_UP) ctl.nop(4'hf);
    rbits(REG_CTRL, 32'hffff_ffff, 32'h1);
    rbits(REG_MODE, 32'hffff_ffff, 32'h0);
    rbits(REG_COLOUR, 32'hffff_ffff, 32'h0);
    rbits(8'h40, 32'hffff_ffff, 32'h0);
    check({30'h0, hreadyout, hresp}, 32'h2);
    ctl.cmd(3'b010, 1'b0, 11'h200, 32'h0, 4'hf);
    ctl.idle(4);
    repeat (2) begin
      ctl.cmd(3'b001, 1'b0, 11'h000, 32'h0, 4'hf);
      ctl.idle(12);
    end
    rbits(REG_REFRESH, 32'h3ff, 32'h2);
    ctl.cmd(3'b000, 1'b0, 11'h032, 32'h0, 4'h0);
    ctl.cmd(3'b000, 1'b1, 11'h040, COL, 4'h0);
    ctl.cmd(3'b000, 1'b1, 11'h020, 32'hffff_ffff, 4'h0);
    ctl.cmd(3'b000, 1'b1, 11'h79f, 32'h0, 4'h0);
    ctl.idle(1);
    rbits(REG_MODE, 32'hffff_ffff, 32'h032);
    rbits(REG_COLOUR, 32'hffff_ffff, COL);
    rbits(REG_MASK, 32'hffff_ffff, 32'hffff_ffff);
    // Burst of four from column 6 wraps to 4; byte masks on both ways
    ctl.cmd(3'b011, 1'b0, 11'h003, 32'h0, 4'h0);
    ctl.idle(3);
    ctl.cmd(3'b100, 1'b0, 11'h006, 32'ha5a5_a500, 4'h0);
    for (int i = 1; i < 4; i++) begin
      ctl.cmd(3'b111, 1'b0, 11'h000, 32'ha5a5_a500 + 32'(i), 4'h0);
    end
    ctl.cmd(3'b100, 1'b0, 11'h006, 32'h5a5a_5a5a, 4'h2);
    ctl.clear();
    ctl.cmd(3'b101, 1'b0, 11'h006, 32'h0, 4'h0);
    ctl.nop(4'h0);
    ctl.nop(4'h1);
    ctl.idle(6);
    check(32'(ctl.oe_q.size()), 32'h4);
    beat(32'h5a5a_a55a, 32'hffff_ffff);
    beat(32'ha5a5_a501, 32'hffff_ff00);
    beat(32'ha5a5_a502, 32'hffff_ffff);
    beat(32'ha5a5_a503, 32'hffff_ffff);
    cut(3'b110, 11'h004, 32'h4);
    cut(3'b010, 11'h004, 32'h3);
    // Bank B with per-bit masking, bank A plain
    ctl.cmd(3'b011, 1'b1, 11'h401, 32'h0, 4'h0);
    ctl.idle(1);
    ctl.cmd(3'b011, 1'b0, 11'h003, 32'h0, 4'h0);
    ctl.idle(3);
    rbits(REG_STATUS, 32'hffff_ffff, 32'h0000_000b);
    ctl.cmd(3'b100, 1'b0, 11'h411, D1, 4'h0);
    ctl.idle(4);
    ctl.cmd(3'b000, 1'b1, 11'h020, MSK, 4'h0);
    ctl.cmd(3'b100, 1'b1, 11'h410, 32'h0202_0202, 4'h0);
    ctl.cmd(3'b100, 1'b1, 11'h010, 32'h0202_0202, 4'h0);
    rdw(11'h611);
    beat((COL & MSK) | (D1 & ~MSK), 32'hffff_ffff);
    rbits(REG_STATUS, 32'h3, 32'h1);
    rdw(11'h011);
    beat(COL, 32'hffff_ffff);
    ctl.cmd(3'b011, 1'b1, 11'h401, 32'h0, 4'h0);
    ctl.idle(3);
    ctl.idle(2);
    ctl.cmd(3'b010, 1'b0, 11'h400, 32'h0, 4'h0);
    ctl.idle(4);
    rbits(REG_STATUS, 32'h3, 32'h1);
    ctl.cmd(3'b010, 1'b0, 11'h600, 32'h0, 4'h0);
    ctl.idle(4);
    rbits(REG_STATUS, 32'h3, 32'h0);
    // Power down ignores commands until the clock enable returns
    ctl.set_cke(1'b0);
    ctl.cmd(3'b000, 1'b0, 11'h027, 32'h0, 4'h0);
    rbits(REG_STATUS, 32'h20, 32'h20);
    ctl.set_cke(1'b1);
    ctl.idle(2);
    rbits(REG_STATUS, 32'h20, 32'h0);
    ahb(1'b1, REG_CTRL, 32'h0);
    ctl.cmd(3'b000, 1'b0, 11'h027, 32'h0, 4'h0);
    ctl.idle(1);
    rbits(REG_MODE, 32'hffff_ffff, 32'h032);
    ahb(1'b1, REG_CTRL, 32'h1);
    rbits(REG_CTRL, 32'hffff_ffff, 32'h1);
    // Unselected writes leave the enable alone; a read ignores high address bits
    ahb(1'b1, REG_CTRL, 32'h0, 1'b0);
    ahb(1'b0, REG_CTRL, 32'h0, 1'b1, 24'ha55a3c);
    check(rd, 32'h1);
    // Deselected strobes are no command
    ctl.desel(11'h027);
    ctl.idle(1);
    rbits(REG_MODE, 32'hffff_ffff, 32'h032);
    // Full page at the shorter read latency, cut by burst stop
    ctl.cmd(3'b000, 1'b0, 11'h027, 32'h0, 4'h0);
    ctl.cmd(3'b011, 1'b0, 11'h003, 32'h0, 4'h0);
    ctl.idle(3);
    cut(3'b110, 11'h000, 32'h3);
    rbits(REG_MODE, 32'hffff_ffff, 32'h027);
    // Interleaved burst of four from column 5 runs 5, 4, 7, 6
    ctl.cmd(3'b010, 1'b0, 11'h200, 32'h0, 4'h0);
    ctl.idle(4);
    ctl.cmd(3'b000, 1'b0, 11'h03a, 32'h0, 4'h0);
    ctl.cmd(3'b011, 1'b0, 11'h003, 32'h0, 4'h0);
    ctl.idle(3);
    rdw(11'h005);
    beat(32'ha5a5_a503, 32'hffff_ffff);
    beat(32'ha5a5_a502, 32'hffff_ffff);
    // Reset in mid-run brings back the reset values
    hresetn <= 1'b0;
    ctl.idle(2);
    hresetn <= 1'b1;
    ctl.idle(2);
    rbits(REG_MODE, 32'hffff_ffff, 32'h0);
    rbits(REG_STATUS, 32'hffff_ffff, 32'h0);
    rbits(REG_CTRL, 32'hffff_ffff, 32'h1);
    complete_run();
  end
endmodule : graphics_sync_dram_command_interface_bench
